// file: verif/adc_serial_ctrl_asserts.sv
// Port checks for the serial converter control block
`timescale 1ns/100ps
module adc_serial_ctrl_asserts (
    // Clock and reset
    input wire MCLK,
    input wire RST,
    // Serial pins
    input wire CS_N,
    input wire DATA_OUT_OE,
    // Analog core control
    input wire [3:0] MUX_SEL,
    input wire SAMPLE,
    input wire HOLD
);
    reg [5:0] hold_cnt;
    always @(posedge MCLK) begin
        hold_cnt <= (RST || !HOLD) ? 6'h00 : hold_cnt + 6'h01;
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_held_low; !CS_N [*4]; endsequence
    sequence s_conv_end; $fell(HOLD) ##0 CS_N; endsequence
    property p_oe_off; CS_N [*4] |=> !DATA_OUT_OE; endproperty
    a_oe_off: assert property (p_oe_off) else $error("data pin driven while deselected");
    property p_oe_rise; $rose(DATA_OUT_OE) |-> !$past(CS_N, 3) && !$past(CS_N, 4); endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("select taken too early");
    property p_oe_on; $fell(CS_N) ##0 !CS_N [*8] |-> DATA_OUT_OE; endproperty
    a_oe_on: assert property (p_oe_on) else $error("data pin not driven");
    property p_oe_keep; s_held_low ##0 DATA_OUT_OE |=> DATA_OUT_OE; endproperty
    a_oe_keep: assert property (p_oe_keep) else $error("data pin dropped");
    property p_hold_start; $fell(SAMPLE) && !CS_N |-> HOLD; endproperty
    a_hold_start: assert property (p_hold_start) else $error("hold not entered");
    property p_hold_after_sample; $rose(HOLD) |-> $past(SAMPLE); endproperty
    a_hold_after_sample: assert property (p_hold_after_sample) else $error("hold without sampling");
    property p_conv_min; s_conv_end |-> hold_cnt >= 6'd44; endproperty
    a_conv_min: assert property (p_conv_min) else $error("conversion too short");
    property p_conv_max; HOLD |-> hold_cnt <= 6'd45; endproperty
    a_conv_max: assert property (p_conv_max) else $error("conversion too long");
    property p_mux_range; SAMPLE |-> MUX_SEL <= 4'hB; endproperty
    a_mux_range: assert property (p_mux_range) else $error("channel out of range");
    property p_mux_stable; HOLD && $past(HOLD) |-> $stable(MUX_SEL); endproperty
    a_mux_stable: assert property (p_mux_stable) else $error("channel moved in hold");
endmodule // adc_serial_ctrl_asserts

// file: verif/host_model.sv
// Controller model driving select, I/O clock and address lines
`timescale 1ns/100ps
module host_model (
    // Data pin as seen on the board
    input wire data_pin,
    // Control lines
    output reg cs_n,
    output reg io_clk,
    output reg addr_in
);
    initial begin
        cs_n = 1'b1;
        io_clk = 1'b0;
        addr_in = 1'b0;
    end
    // One frame; gap 0 keeps select low, gap 8 cuts the conversion short
    task frame(input [3:0] addr, input integer gap, output [9:0] rd);
        integer i;
        begin
            cs_n = 1'b0;
            #80;
            for (i = 0; i < 10; i = i + 1) begin
                addr_in = (i < 4) ? addr[3 - i] : ~addr_in;
                #32 io_clk = 1'b1;
                #32 rd[9 - i] = data_pin;
                io_clk = 1'b0;
            end
            addr_in = ~addr_in;
            if (gap == 0)
                #480;
            else begin
                #32 cs_n = 1'b1;
                #(gap * 8);
            end
        end
    endtask
endmodule // host_model

// file: verif/testbench.sv
// Self-checking bench for the serial converter control block
`timescale 1ns/100ps
module testbench;
    reg MCLK;
    reg RST;
    reg [9:0] vin [0:11];
    reg [9:0] last;
    reg [9:0] got;
    integer n_errors, compares, cycles, i;
    wire CS_N, IO_CLK, ADDR_IN, DATA_OUT, DATA_OUT_OE, SAMPLE, HOLD;
    wire [3:0] MUX_SEL;
    wire [9:0] DAC_CODE;
    wire data_pin = DATA_OUT_OE ? DATA_OUT : 1'bz;
    wire COMP_IN = vin[MUX_SEL] >= DAC_CODE;
    adc_serial_ctrl DUT (.MCLK(MCLK), .RST(RST), .CE(1'b1), .CS_N(CS_N), .IO_CLK(IO_CLK),
        .ADDR_IN(ADDR_IN), .COMP_IN(COMP_IN), .DATA_OUT(DATA_OUT), .DATA_OUT_OE(DATA_OUT_OE),
        .MUX_SEL(MUX_SEL), .SAMPLE(SAMPLE), .HOLD(HOLD), .DAC_CODE(DAC_CODE));
    host_model u_host (.data_pin(data_pin), .cs_n(CS_N), .io_clk(IO_CLK), .addr_in(ADDR_IN));
    task check(input [79:0] what, input [9:0] exp, input [9:0] seen);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (n_errors == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Reads the previous result and books the one this frame starts, unless gap 8 has it cut short
    task t_frame(input [3:0] a, input integer gap);
        begin
            u_host.frame(a, gap, got);
            check("result", last, got);
            if (gap != 8)
                last = vin[(a > 4'hB) ? 4'hB : a];
        end
    endtask
    task t_chain;
        begin
            t_frame(4'h5, 50);
            t_frame(4'h6, 0);
            t_frame(4'h2, 50);
            t_frame(4'hB, 0);
            t_frame(4'hE, 50);
            t_frame(4'h7, 50);
        end
    endtask
    task t_abort;
        begin
            t_frame(4'h1, 8);
            t_frame(4'h3, 50);
        end
    endtask
    // Select glitch, then clock and address toggling while deselected
    task t_deselect;
        reg [3:0] mux_was;
        begin
            mux_was = MUX_SEL;
            u_host.cs_n = 1'b0;
            #8 u_host.cs_n = 1'b1;
            for (i = 0; i < 12; i = i + 1) begin
                u_host.io_clk = ~u_host.io_clk;
                u_host.addr_in = i[0];
                #32;
                check("idle", {6'h00, mux_was}, {DATA_OUT_OE, SAMPLE, HOLD, 3'h0, MUX_SEL});
            end
        end
    endtask
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            tally_and_finish;
        end
    end
    initial begin
        n_errors = 0;
        compares = 0;
        cycles = 0;
        last = 10'h000;
        for (i = 0; i < 12; i = i + 1)
            vin[i] = 10'h2C3 - i * 10'h03B;
        vin[5] = 10'h3FF;
        vin[6] = 10'h000;
        RST = 1'b1;
        repeat (6) @(negedge MCLK);
        RST = 1'b0;
        @(negedge MCLK);
        check("reset", 10'h000, {DATA_OUT_OE, SAMPLE, HOLD, MUX_SEL, 3'h0});
        check("dac", 10'h000, DAC_CODE);
        t_chain;
        t_abort;
        t_deselect;
        t_frame(4'h0, 50);
        tally_and_finish;
    end
endmodule // testbench
bind adc_serial_ctrl adc_serial_ctrl_asserts u_chk (.MCLK(MCLK), .RST(RST), .CS_N(CS_N),
    .DATA_OUT_OE(DATA_OUT_OE), .MUX_SEL(MUX_SEL), .SAMPLE(SAMPLE), .HOLD(HOLD));

// file: verilog/adc_sar_engine.v
// Successive approximation engine that runs one conversion over a fixed cycle count
`timescale 1ns/100ps
`include "adc_serial_defs.vh"

module adc_sar_engine (
    // Clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // Control
    input wire start,
    input wire abort,
    // Comparator, already synchronised: high when input is at or above the trial level
    input wire comp,
    // Results
    output reg [9:0] dac_code,
    output reg [9:0] code,
    output reg busy,
    output reg done
);

reg [5:0] cyc;
reg [1:0] phase;
reg [9:0] mask;
reg [9:0] kept;

always @* begin
    // Keep the trial bit only when the input reached it; this pins extremes to the rails
    kept = comp ? dac_code : (dac_code & ~mask);
end

always @(posedge clk) begin
    if (rst) begin
        dac_code <= `ADC_RESULT_RESET;
        code <= `ADC_RESULT_RESET;
        busy <= 1'b0;
        done <= 1'b0;
        cyc <= 6'd0;
        phase <= 2'd0;
        mask <= 10'h000;
    end else if (ce) begin
        done <= 1'b0;
        if (abort) begin
            busy <= 1'b0;
            mask <= 10'h000;
            dac_code <= `ADC_RESULT_RESET;
        end else if (start) begin
            busy <= 1'b1;
            cyc <= 6'd0;
            phase <= 2'd0;
            mask <= `ADC_TRIAL_FIRST;
            dac_code <= `ADC_TRIAL_FIRST;
        end else if (busy) begin
            cyc <= cyc + 6'd1;
            phase <= phase + 2'd1;
            if (mask != 10'h000 && phase == `ADC_BIT_CYCLES) begin
                mask <= mask >> 1;
                dac_code <= kept | (mask >> 1);
            end
            if (cyc == `ADC_CONV_CYCLES - 6'd1) begin
                busy <= 1'b0;
                done <= 1'b1;
                code <= dac_code;
            end
        end
    end
end

endmodule // adc_sar_engine

// file: verilog/adc_serial_ctrl.v
// Serial control logic of a ten-bit converter with a twelve-way input selector
`timescale 1ns/100ps
`include "adc_serial_defs.vh"


module adc_serial_ctrl (
    // Clock, reset, enable
    input wire MCLK,
    input wire RST,
    input wire CE,
    // Serial control pins
    input wire CS_N,
    input wire IO_CLK,
    input wire ADDR_IN,
    // Comparator from the analog core
    input wire COMP_IN,
    // Serial data pin
    output reg DATA_OUT,
    output reg DATA_OUT_OE,
    // Analog core control
    output reg [3:0] MUX_SEL,
    output reg SAMPLE,
    output reg HOLD,
    output wire [9:0] DAC_CODE
);

localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_ARM = 4'b0010;
localparam [3:0] ST_SHIFT = 4'b0100;
localparam [3:0] ST_BUSY = 4'b1000;

reg [3:0] state;
reg cs_s1;
reg cs_s2;
reg io_s1;
reg io_s2;
reg io_d;
reg addr_s1;
reg addr_s2;
reg comp_s1;
reg comp_s2;
reg [1:0] filt;
reg [2:0] rise_cnt;
reg [3:0] fall_cnt;
reg [3:0] addr_shift;
reg [9:0] result;
reg [9:0] shift_out;
reg sar_start;
reg sar_abort;
wire io_rise;
wire io_fall;
wire [9:0] sar_code;
wire sar_busy;
wire sar_done;

// Addresses above the self-test code also land on the self-test level
function [3:0] chan_map;
    input [3:0] addr;
    begin
        chan_map = (addr > `ADC_SELFTEST_CHAN) ? `ADC_SELFTEST_CHAN : addr;
    end
endfunction

assign io_rise = io_s2 & ~io_d;
assign io_fall = ~io_s2 & io_d;

adc_sar_engine u_sar (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .start(sar_start),
    .abort(sar_abort),
    .comp(comp_s2),
    .dac_code(DAC_CODE),
    .code(sar_code),
    .busy(sar_busy),
    .done(sar_done)
);

always @(posedge MCLK) begin
    if (RST) begin
        state <= ST_IDLE;
        cs_s1 <= 1'b1;
        cs_s2 <= 1'b1;
        io_s1 <= 1'b0;
        io_s2 <= 1'b0;
        io_d <= 1'b0;
        addr_s1 <= 1'b0;
        addr_s2 <= 1'b0;
        comp_s1 <= 1'b0;
        comp_s2 <= 1'b0;
        filt <= 2'd0;
        rise_cnt <= 3'd0;
        fall_cnt <= 4'd0;
        addr_shift <= `ADC_CHAN_RESET;
        result <= `ADC_RESULT_RESET;
        shift_out <= `ADC_RESULT_RESET;
        sar_start <= 1'b0;
        sar_abort <= 1'b0;
        DATA_OUT <= 1'b0;
        DATA_OUT_OE <= 1'b0;
        MUX_SEL <= `ADC_CHAN_RESET;
        SAMPLE <= 1'b0;
        HOLD <= 1'b0;
    end else if (CE) begin
        // Pin synchronisers; the second stage is read, and io_d behind it as well for I/O clock edges
        cs_s1 <= CS_N;
        cs_s2 <= cs_s1;
        io_s1 <= IO_CLK;
        io_s2 <= io_s1;
        io_d <= io_s2;
        addr_s1 <= ADDR_IN;
        addr_s2 <= addr_s1;
        comp_s1 <= COMP_IN;
        comp_s2 <= comp_s1;
        sar_start <= 1'b0;
        sar_abort <= 1'b0;
        // A result landing as an abort goes out is dropped; the frame shows the old one
        if (sar_done && !sar_abort) begin
            result <= sar_code;
            HOLD <= 1'b0;
        end
        case (state)
            ST_IDLE: begin
                DATA_OUT_OE <= 1'b0;
                if (!cs_s2) begin
                    filt <= 2'd1;
                    state <= ST_ARM;
                end
            end
            ST_ARM: begin
                // Any high sample restarts the noise filter
                if (cs_s2) begin
                    state <= ST_IDLE;
                end else if (filt == `ADC_CS_FILTER - 2'd1) begin
                    state <= ST_SHIFT;
                    rise_cnt <= 3'd0;
                    fall_cnt <= 4'd0;
                    DATA_OUT_OE <= 1'b1;
                    shift_out <= sar_done ? sar_code : result;
                    DATA_OUT <= sar_done ? sar_code[`ADC_RES_MSB] : result[`ADC_RES_MSB];
                    // A done in this same cycle wins and is shown instead of aborting
                    if (sar_busy && !sar_done) begin
                        sar_abort <= 1'b1;
                        HOLD <= 1'b0;
                    end
                end else begin
                    filt <= filt + 2'd1;
                end
            end
            ST_SHIFT: begin
                if (cs_s2) begin
                    state <= ST_IDLE;
                    DATA_OUT_OE <= 1'b0;
                    SAMPLE <= 1'b0;
                end else begin
                    // Rises past the fourth carry no address and are ignored
                    if (io_rise && rise_cnt < `ADC_ADDR_EDGES) begin
                        addr_shift <= {addr_shift[2:0], addr_s2};
                        rise_cnt <= rise_cnt + 3'd1;
                    end
                    if (io_fall) begin
                        fall_cnt <= fall_cnt + 4'd1;
                        if (fall_cnt < `ADC_DATA_EDGES) begin
                            shift_out <= {shift_out[8:0], 1'b0};
                            DATA_OUT <= shift_out[`ADC_RES_MSB - 1];
                        end else begin
                            DATA_OUT <= 1'b0;
                        end
                        if (fall_cnt == `ADC_SAMPLE_EDGE - 4'd1) begin
                            MUX_SEL <= chan_map(addr_shift);
                            SAMPLE <= 1'b1;
                        end
                        // Tenth fall: close sampling, hold and start the conversion
                        if (fall_cnt == `ADC_LAST_EDGE - 4'd1) begin
                            MUX_SEL <= chan_map(addr_shift);
                            SAMPLE <= 1'b0;
                            HOLD <= 1'b1;
                            sar_start <= 1'b1;
                            state <= ST_BUSY;
                        end
                    end
                end
            end
            ST_BUSY: begin
                // I/O clock is ignored until the conversion ends
                if (cs_s2) begin
                    state <= ST_IDLE;
                    DATA_OUT_OE <= 1'b0;
                end else if (sar_done) begin
                    state <= ST_SHIFT;
                    rise_cnt <= 3'd0;
                    fall_cnt <= 4'd0;
                    shift_out <= sar_code;
                    DATA_OUT <= sar_code[`ADC_RES_MSB];
                end
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

endmodule // adc_serial_ctrl

// file: verilog/adc_serial_defs.vh
// Constants shared by the serial converter control block and its approximation engine
`ifndef ADC_SERIAL_DEFS_VH
`define ADC_SERIAL_DEFS_VH

// Conversion timing, in system clock cycles
`define ADC_CONV_CYCLES 6'd44
`define ADC_BIT_CYCLES 2'd3
`define ADC_CS_FILTER 2'd3

// Serial frame edge counts
`define ADC_ADDR_EDGES 3'd4
`define ADC_SAMPLE_EDGE 4'd4
`define ADC_DATA_EDGES 4'd9
`define ADC_LAST_EDGE 4'd10

// Result layout and reset values
`define ADC_RES_MSB 9
`define ADC_RESULT_RESET 10'h000
`define ADC_TRIAL_FIRST 10'h200
`define ADC_CODE_ALL_ONES 10'h3FF
`define ADC_CODE_ALL_ZEROS 10'h000

// Channel selector
`define ADC_CHAN_RESET 4'h0
`define ADC_SELFTEST_CHAN 4'hB

`endif
